// *** bsmd_cond.sv ***
// Branch condition evaluation from the flag register
`timescale 1ns/1ps
module bsmd_cond (
    // Inputs
    input wire logic [7:0] flags_i,
    input wire logic [3:0] cond_i,
    // Result
    output logic taken_o
);
    import bsmd_pkg::*;

    wire c = flags_i[FLG_C];
    wire z = flags_i[FLG_Z];
    wire v = flags_i[FLG_V];
    wire n = flags_i[FLG_N];
    wire nv = n ^ v;

    always_comb begin
        case (cond_i)
            4'h0: taken_o = 1'b1;
            4'h1: taken_o = 1'b0;
            4'h2: taken_o = ~(c | z);
            4'h3: taken_o = c | z;
            4'h4: taken_o = ~c;
            4'h5: taken_o = c;
            4'h6: taken_o = ~z;
            4'h7: taken_o = z;
            4'h8: taken_o = ~v;
            4'h9: taken_o = v;
            4'hA: taken_o = ~n;
            4'hB: taken_o = n;
            4'hC: taken_o = ~nv;
            4'hD: taken_o = nv;
            4'hE: taken_o = ~(z | nv);
            default: taken_o = z | nv;
        endcase
    end

endmodule : bsmd_cond

// *** bsmd_core.sv ***
// Branch, system-control and block-move execution unit with Wishbone registers
// Operation
// - Conditional branch loads target only when true
// - Sixteen branch conditions from the flags
// - Both call forms jump and keep return
// - Return reloads saved address into counter
// - Trap enters exception sequence, not next
// - Exception return restores context and resumes
// - Sleep enters the power-down state
// - Flag load copies source, word read
// - Flag store copies flags, word write
// - Flag AND with 8-bit immediate
// - Flag OR with 8-bit immediate
// - Flag XOR with 8-bit immediate
// - No-operation only advances counter by two
// - Block move copies bytes source to destination
// - Step pointers, count down, zero moves nothing
// - After block move continue with next
// - Instructions are whole 16-bit words
// - Operation field holds first four bits
// - Register fields of three or four bits
// - Extension 8/16/32 bits, 24-bit zero-topped
// - Condition field picks branch condition
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module bsmd_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Memory system
    output bsmd_pkg::bsmd_mreq_s mem_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    // Power-down
    output logic sleep_o
);
    import bsmd_pkg::*;

    // ******************************
    // Functions
    // ******************************
    // Only the low 24 address bits reach the memory system
    function automatic bsmd_mreq_s mk_req(input logic we, input logic bsz,
                                          input logic [31:0] addr,
                                          input logic [15:0] data);
        bsmd_mreq_s r;
        r.req = 1'b1;
        r.we = we;
        r.byte_sz = bsz;
        r.addr = addr[23:0];
        r.wdata = data;
        return r;
    endfunction : mk_req

    function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_sel

    // ******************************
    // State
    // ******************************
    bsmd_state_e state_q;
    bsmd_mreq_s mem_q;
    bsmd_fields_s fld;
    logic run_q, bad_q, sleep_q, ack_q;
    logic [23:0] pc_q;
    logic [31:0] sp_q, src_q, dst_q, rdat_q;
    logic [15:0] cnt_q, ir_q;
    logic [7:0] flg_q, move_byte_q;
    logic [31:0] ext_q;
    logic [1:0] ext_n_q, step_q;
    logic cond_true;

    // ******************************
    // Decode
    // ******************************
    bsmd_decode u_dec (
        .instr_i(ir_q),
        .fields_o(fld)
    );

    bsmd_cond u_cond (
        .flags_i(flg_q),
        .cond_i(fld.cond),
        .taken_o(cond_true)
    );

    // ******************************
    // Bus decode
    // ******************************
    wire bus_hit = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_hit & wb_we_i;
    wire halted = (state_q == S_IDLE);
    // Core registers change only while halted, so software never races the sequencer
    wire core_wr = bus_wr & halted;
    wire wr_ctrl = bus_wr & (wb_adr_i == ADR_CTRL);
    wire wake = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_WAKE];
    wire [31:0] status_w = {29'h0, bad_q, sleep_q, ~halted};
    wire [31:0] rd_mux =
        (wb_adr_i == ADR_CTRL) ? {31'h0, run_q} :
        (wb_adr_i == ADR_STATUS) ? status_w :
        (wb_adr_i == ADR_PC) ? {8'h00, pc_q} :
        (wb_adr_i == ADR_SP) ? sp_q :
        (wb_adr_i == ADR_FLAGS) ? {24'h0, flg_q} :
        (wb_adr_i == ADR_SRC) ? src_q :
        (wb_adr_i == ADR_DST) ? dst_q :
        (wb_adr_i == ADR_CNT) ? {16'h0, cnt_q} : 32'h0;

    // ******************************
    // Execution decode
    // ******************************
    wire mem_done = mem_q.req & mem_ack_i;
    wire bsmd_state_e nxt = run_q ? S_FETCH : S_IDLE;
    wire [23:0] disp = {{16{fld.imm[7]}}, fld.imm};
    wire [23:0] rel_tgt = pc_q + disp;
    wire [23:0] abs_tgt = ext_q[23:0];
    wire [23:0] trap_tgt = TRAP_VEC_BASE + {20'h0, fld.imm[1:0], 2'b00};
    wire move_word = fld.op2[0];
    wire [15:0] cnt_cur = move_word ? cnt_q : {8'h00, cnt_q[7:0]};
    wire cnt_zero = (cnt_cur == 16'h0000);
    wire [15:0] cnt_dec = move_word ? cnt_q - 16'h0001 : {cnt_q[15:8], cnt_q[7:0] - 8'h01};
    wire is_push = (fld.op == OP_BSR) | (fld.op == OP_JSR) | (fld.op == OP_TRAP);
    wire is_pop = (fld.op == OP_RTS) | (fld.op == OP_RTE);
    wire is_mem = is_push | is_pop | (fld.op == OP_STC) |
                  ((fld.op == OP_LDC) & (fld.amode != 2'd0));
    wire [1:0] nsteps = ((fld.op == OP_TRAP) | (fld.op == OP_RTE)) ? 2'd3 :
                        (is_push | is_pop) ? 2'd2 : 2'd1;
    wire [31:0] ind_addr = (fld.areg == 3'd5) ? src_q :
                           (fld.areg == 3'd6) ? dst_q : sp_q;
    wire [31:0] ldst_addr = (fld.amode == 2'd2) ? ind_addr : {16'h0, ext_q[15:0]};
    // stack words: low return, high return, flags
    wire [15:0] push_word = (step_q == 2'd0) ? pc_q[15:0] :
                            (step_q == 2'd1) ? {8'h00, pc_q[23:16]} : {flg_q, 8'h00};
    wire [31:0] sp_dn = sp_q - WORD_STEP;
    wire [31:0] sp_up = sp_q + WORD_STEP;
    // Flags sit in the upper byte of the memory word
    wire bsmd_mreq_s op_req = is_push ? mk_req(1'b1, 1'b0, sp_dn, push_word) :
                              is_pop ? mk_req(1'b0, 1'b0, sp_q, 16'h0000) :
                              mk_req(fld.op == OP_STC, 1'b0, ldst_addr, {flg_q, 8'h00});
    // Which pop step carries the high and low return halves
    wire [1:0] pop_hi = (fld.op == OP_RTE) ? 2'd1 : 2'd0;
    wire [1:0] pop_lo = (fld.op == OP_RTE) ? 2'd2 : 2'd1;

    // ******************************
    // Bus registers
    // ******************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            run_q <= 1'b0;
        end else begin
            ack_q <= bus_hit;
            rdat_q <= bus_hit ? rd_mux : 32'h0;
            if (wr_ctrl & wb_sel_i[0]) begin
                run_q <= wb_dat_i[CTRL_RUN];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign mem_o = mem_q;
    assign sleep_o = sleep_q;

    // ******************************
    // Sequencer
    // ******************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            mem_q <= '0;
            bad_q <= 1'b0;
            sleep_q <= 1'b0;
            pc_q <= PC_RST;
            sp_q <= SP_RST;
            src_q <= 32'h0;
            dst_q <= 32'h0;
            cnt_q <= 16'h0;
            flg_q <= FLAGS_RST;
            ir_q <= 16'h0;
            ext_q <= 32'h0;
            ext_n_q <= 2'd0;
            step_q <= 2'd0;
            move_byte_q <= 8'h00;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (core_wr) begin
                        case (wb_adr_i)
                            ADR_STATUS: bad_q <= bad_q & ~(wb_sel_i[0] & wb_dat_i[ST_BAD]);
                            ADR_PC: pc_q <= 24'(merge_sel({8'h00, pc_q}, wb_dat_i, wb_sel_i));
                            ADR_SP: sp_q <= merge_sel(sp_q, wb_dat_i, wb_sel_i);
                            ADR_FLAGS: flg_q <= 8'(merge_sel({24'h0, flg_q}, wb_dat_i, wb_sel_i));
                            ADR_SRC: src_q <= merge_sel(src_q, wb_dat_i, wb_sel_i);
                            ADR_DST: dst_q <= merge_sel(dst_q, wb_dat_i, wb_sel_i);
                            ADR_CNT: cnt_q <= 16'(merge_sel({16'h0, cnt_q}, wb_dat_i, wb_sel_i));
                            default: ;
                        endcase
                    end
                    if (run_q) begin
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (!mem_q.req) begin
                        mem_q <= mk_req(1'b0, 1'b0, {8'h00, pc_q}, 16'h0000);
                    end else if (mem_done) begin
                        mem_q.req <= 1'b0;
                        ir_q <= mem_rdata_i;
                        pc_q <= pc_q + INSN_BYTES;
                        ext_q <= 32'h0;
                        ext_n_q <= 2'd0;
                        step_q <= 2'd0;
                        state_q <= S_EXT;
                    end
                end
                S_EXT: begin
                    if (ext_n_q == fld.ext_words) begin
                        state_q <= S_EXEC;
                    end else if (!mem_q.req) begin
                        mem_q <= mk_req(1'b0, 1'b0, {8'h00, pc_q}, 16'h0000);
                    end else if (mem_done) begin
                        mem_q.req <= 1'b0;
                        ext_q <= {ext_q[15:0], mem_rdata_i};
                        pc_q <= pc_q + INSN_BYTES;
                        ext_n_q <= ext_n_q + 2'd1;
                    end
                end
                S_EXEC: begin
                    state_q <= nxt;
                    if (is_mem) begin
                        state_q <= S_MEMOP;
                    end
                    case (fld.op)
                        OP_NOP: ;
                        OP_BCC: begin
                            if (cond_true) begin
                                pc_q <= rel_tgt;
                            end
                        end
                        OP_JMP: pc_q <= abs_tgt;
                        OP_SLEEP: begin
                            sleep_q <= 1'b1;
                            state_q <= S_SLEEP;
                        end
                        OP_LDC: begin
                            if (fld.amode == 2'd0) begin
                                flg_q <= fld.imm;
                            end
                        end
                        OP_FLAG_AND_IMMEDIATE: flg_q <= flg_q & fld.imm;
                        OP_ORC: flg_q <= flg_q | fld.imm;
                        OP_FLAG_XOR_IMMEDIATE: flg_q <= flg_q ^ fld.imm;
                        OP_MOVE: state_q <= S_MOVE;
                        OP_BAD: bad_q <= 1'b1;
                        default: ;
                    endcase
                end
                S_MEMOP: begin
                    if (step_q == nsteps) begin
                        state_q <= nxt;
                        case (fld.op)
                            OP_BSR: pc_q <= rel_tgt;
                            OP_JSR: pc_q <= abs_tgt;
                            OP_TRAP: begin
                                pc_q <= trap_tgt;
                                flg_q[FLG_I] <= 1'b1;
                            end
                            default: ;
                        endcase
                    end else if (!mem_q.req) begin
                        mem_q <= op_req;
                    end else if (mem_done) begin
                        mem_q.req <= 1'b0;
                        step_q <= step_q + 2'd1;
                        if (is_push) begin
                            sp_q <= sp_dn;
                        end
                        if (is_pop) begin
                            sp_q <= sp_up;
                        end
                        if (fld.op == OP_LDC) begin
                            flg_q <= mem_rdata_i[15:8];
                        end
                        if (fld.op == OP_RTE && step_q == 2'd0) begin
                            flg_q <= mem_rdata_i[15:8];
                        end
                        if (is_pop && step_q == pop_hi) begin
                            pc_q[23:16] <= mem_rdata_i[7:0];
                        end
                        if (is_pop && step_q == pop_lo) begin
                            pc_q[15:0] <= mem_rdata_i;
                        end
                    end
                end
                S_MOVE: begin
                    if (step_q == 2'd0 && cnt_zero) begin
                        state_q <= nxt;
                    end else if (!mem_q.req) begin
                        mem_q <= (step_q == 2'd0) ?
                            mk_req(1'b0, 1'b1, src_q, 16'h0000) :
                            mk_req(1'b1, 1'b1, dst_q, {8'h00, move_byte_q});
                    end else if (mem_done) begin
                        mem_q.req <= 1'b0;
                        if (step_q == 2'd0) begin
                            move_byte_q <= mem_rdata_i[7:0];
                            step_q <= 2'd1;
                        end else begin
                            src_q <= src_q + BYTE_STEP;
                            dst_q <= dst_q + BYTE_STEP;
                            cnt_q <= cnt_dec;
                            step_q <= 2'd0;
                        end
                    end
                end
                S_SLEEP: begin
                    if (wake) begin
                        sleep_q <= 1'b0;
                        state_q <= nxt;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule : bsmd_core

// *** bsmd_core_monitor.sv ***
// Port checker bound to the execution unit
`timescale 1ns/1ps
module bsmd_core_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Observed ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire bsmd_pkg::bsmd_mreq_s mem_o,
    input wire logic mem_ack_i,
    input wire logic sleep_o
);
    import bsmd_pkg::*;
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    req_hold_a: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
        else $error("memory request changed before answer");
    req_drop_a: assert property (mem_o.req && mem_ack_i |=> !mem_o.req)
        else $error("memory request kept after answer");
    word_even_a: assert property (mem_o.req && !mem_o.byte_sz |-> !mem_o.addr[0])
        else $error("odd word access");
    sleep_quiet_a: assert property (sleep_o && $past(sleep_o) |-> !mem_o.req)
        else $error("memory access while powered down");
    // Judged at the first edge out of reset, so the pre-reset unknowns never count
    reset_quiet_a: assert property (disable iff (1'b0) $fell(rst_i) |-> !mem_o.req && !sleep_o)
        else $error("outputs active after reset");
    // Power-down entry, byte copy and word writes seen at least once
    sleep_seen_c: cover property ($rose(sleep_o));
    byte_wr_c: cover property (mem_o.req && mem_o.we && mem_o.byte_sz && mem_ack_i);
    word_wr_c: cover property (mem_o.req && mem_o.we && !mem_o.byte_sz && mem_ack_i);
endmodule : bsmd_core_monitor

bind bsmd_core bsmd_core_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .sleep_o(sleep_o));

// *** bsmd_core_tb.sv ***
// Self-checking bench of the branch, system-control and block-move unit
`timescale 1ns/1ps
module bsmd_core_tb;
    import bsmd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic wb_ack_o;
    bsmd_mreq_s mem_o;
    logic mem_ack;
    logic [15:0] mem_rdata;
    logic sleep_o;
    int mismatches = 0;
    int comparisons = 0;
    always #5 clk_i = ~clk_i;
    bsmd_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .sleep_o(sleep_o));
    bsmd_mem_model mem_u (.clk_i(clk_i), .req_i(mem_o), .ack_o(mem_ack), .rdata_o(mem_rdata));
    task automatic results();
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 3000) begin
            mismatches++;
            results();
        end
    endtask : tick
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do tick(n); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk_val(rd, exp);
    endtask : rdchk
    task automatic put(input logic [7:0] a, input logic [15:0] w);
        mem_u.mem[a] = w[15:8];
        mem_u.mem[a + 8'h01] = w[7:0];
    endtask : put
    // Runs from address zero until the core powers down, then wakes it into idle
    task automatic go(input logic [7:0] f);
        int n;
        n = 0;
        wb(1'b1, ADR_FLAGS, {24'h0, f});
        wb(1'b1, ADR_PC, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h1);
        while (sleep_o !== 1'b1) tick(n);
        // Run is cleared first, or the wake would resume fetching
        wb(1'b1, ADR_CTRL, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h2);
    endtask : go
    function automatic logic cond_exp(input logic [3:0] c, input logic [7:0] f);
        logic [7:0] s;
        s = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        return c[0] ^ ~s[c[3:1]];
    endfunction : cond_exp
    task automatic test_branch();
        logic [7:0] fl [4] = '{8'h00, 8'h0F, 8'h08, 8'h05};
        put(8'h00, 16'h0000);
        put(8'h04, 16'h8000);
        put(8'h06, 16'h8000);
        for (int c = 0; c < 16; c++) begin
            foreach (fl[i]) begin
                put(8'h02, {4'h1, c[3:0], 8'h02});
                go(fl[i]);
                rdchk(ADR_PC, cond_exp(c[3:0], fl[i]) ? 32'h8 : 32'h6);
                rdchk(ADR_FLAGS, {24'h0, fl[i]});
            end
        end
    endtask : test_branch
    task automatic test_flags();
        logic [3:0] op [4] = '{4'h9, 4'hB, 4'hC, 4'hD};
        logic [7:0] ex [4] = '{8'h5A, 8'h18, 8'h7E, 8'h66};
        put(8'h02, 16'hA100);
        put(8'h04, 16'h0060);
        put(8'h06, 16'h8000);
        foreach (op[i]) begin
            put(8'h00, {op[i], 4'h0, 8'h5A});
            go(8'h3C);
            rdchk(ADR_FLAGS, {24'h0, ex[i]});
            chk_val({24'h0, mem_u.mem[8'h60]}, {24'h0, ex[i]});
            rdchk(ADR_PC, 32'h8);
        end
    endtask : test_flags
    task automatic test_call();
        put(8'h00, 16'h6000);
        put(8'h02, 16'h3002);
        put(8'h04, 16'h8000);
        put(8'h06, 16'h5000);
        put(8'h20, 16'h7000);
        wb(1'b1, ADR_SP, 32'hF0);
        go(8'h05);
        rdchk(ADR_PC, 32'h6);
        rdchk(ADR_SP, 32'hF0);
        rdchk(ADR_FLAGS, 32'h05);
        chk_val({16'h0, mem_u.mem[8'hEE], mem_u.mem[8'hEF]}, 32'h0004);
        chk_val({16'h0, mem_u.mem[8'hEA], mem_u.mem[8'hEB]}, 32'h0500);
    endtask : test_call
    task automatic test_jump();
        put(8'h00, 16'h4000);
        put(8'h02, 16'h0000);
        put(8'h04, 16'h0030);
        put(8'h30, 16'h5000);
        put(8'h06, 16'h2000);
        put(8'h08, 16'h0000);
        put(8'h0A, 16'h0040);
        put(8'h40, 16'hF000);
        put(8'h42, 16'h8000);
        go(8'h00);
        rdchk(ADR_PC, 32'h44);
        chk_val({16'h0, mem_u.mem[8'hEE], mem_u.mem[8'hEF]}, 32'h0006);
        rdchk(ADR_STATUS, 32'h4);
        wb(1'b1, ADR_STATUS, 32'h4);
        rdchk(ADR_STATUS, 32'h0);
    endtask : test_jump
    task automatic test_move();
        put(8'h40, 16'hA1B2);
        put(8'h42, 16'hC3D4);
        put(8'h00, 16'hE000);
        put(8'h02, 16'h8000);
        wb(1'b1, ADR_SRC, 32'h40);
        wb(1'b1, ADR_DST, 32'h80);
        wb(1'b1, ADR_CNT, 32'h0103);
        go(8'h80);
        chk_val({16'h0, mem_u.mem[8'h80], mem_u.mem[8'h81]}, 32'hA1B2);
        chk_val({16'h0, mem_u.mem[8'h82], mem_u.mem[8'h83]}, 32'hC300);
        rdchk(ADR_SRC, 32'h43);
        rdchk(ADR_CNT, 32'h0100);
        rdchk(ADR_PC, 32'h4);
        put(8'h00, 16'hE100);
        wb(1'b1, ADR_CNT, 32'h0);
        go(8'h80);
        rdchk(ADR_DST, 32'h83);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0);
    endtask : test_move
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        test_branch();
        test_flags();
        test_call();
        test_jump();
        test_move();
        results();
    end
endmodule : bsmd_core_tb

// *** bsmd_decode.sv ***
// Instruction word field extraction
`timescale 1ns/1ps
module bsmd_decode (
    // Instruction word
    input wire logic [15:0] instr_i,
    // Fields
    output bsmd_pkg::bsmd_fields_s fields_o
);
    import bsmd_pkg::*;

    wire bsmd_op_e op = bsmd_op_e'(instr_i[15:12]);
    wire [1:0] amode = instr_i[9:8];

    assign fields_o.op = op;
    assign fields_o.op2 = instr_i[11:8];
    assign fields_o.cond = instr_i[11:8];
    assign fields_o.amode = amode;
    assign fields_o.areg = instr_i[6:4];
    assign fields_o.dreg = instr_i[3:0];
    assign fields_o.imm = instr_i[7:0];
    assign fields_o.ext_words =
        (op == OP_JMP || op == OP_JSR) ? 2'd2 :
        (op == OP_LDC && amode == 2'd1) ? 2'd1 :
        (op == OP_STC && amode != 2'd2) ? 2'd1 : 2'd0;

endmodule : bsmd_decode

// *** bsmd_mem_model.sv ***
// Behavioural memory answering the unit's memory port
`timescale 1ns/1ps
module bsmd_mem_model (
    // Clock
    input wire logic clk_i,
    // Memory port
    input wire bsmd_pkg::bsmd_mreq_s req_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    import bsmd_pkg::*;
    logic [7:0] mem [0:255];
    logic [7:0] a;
    logic [1:0] wait_q = 2'h0;
    logic slow_q = 1'b0;
    assign a = req_i.addr[7:0];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // Alternate prompt and slow answers; data toggles so stale reads never match
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i.req && !ack_o) begin
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else begin
                ack_o <= 1'b1;
                slow_q <= ~slow_q;
                wait_q <= {~slow_q, 1'b0};
                // words are two bytes, high byte first
                if (req_i.we && req_i.byte_sz) begin
                    mem[a] <= req_i.wdata[7:0];
                end else if (req_i.we) begin
                    mem[a] <= req_i.wdata[15:8];
                    mem[a | 8'h01] <= req_i.wdata[7:0];
                end else begin
                    rdata_o <= req_i.byte_sz ? {8'h00, mem[a]} : {mem[a], mem[a | 8'h01]};
                end
            end
        end
    end
endmodule : bsmd_mem_model

// *** bsmd_pkg.sv ***
// Shared constants, types and layouts of the branch, system-control and block-move unit
package bsmd_pkg;

    // ******************************
    // Register map (byte addresses)
    // ******************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_PC = 8'h08;
    localparam logic [7:0] ADR_SP = 8'h0C;
    localparam logic [7:0] ADR_FLAGS = 8'h10;
    localparam logic [7:0] ADR_SRC = 8'h14;
    localparam logic [7:0] ADR_DST = 8'h18;
    localparam logic [7:0] ADR_CNT = 8'h1C;
    localparam logic [7:0] ADR_LIMIT = 8'h20;

    // ******************************
    // Field positions
    // ******************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_WAKE = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_BAD = 2;
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_I = 7;

    // ******************************
    // Reset values and constants
    // ******************************
    localparam logic [23:0] PC_RST = 24'h000000;
    localparam logic [31:0] SP_RST = 32'h0000_0000;
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam logic [23:0] TRAP_VEC_BASE = 24'h000020;
    localparam logic [23:0] INSN_BYTES = 24'h000002;
    localparam logic [31:0] WORD_STEP = 32'h0000_0002;
    localparam logic [31:0] BYTE_STEP = 32'h0000_0001;

    // ******************************
    // Types
    // ******************************
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_BCC = 4'h1, OP_JMP = 4'h2, OP_BSR = 4'h3,
        OP_JSR = 4'h4, OP_RTS = 4'h5, OP_TRAP = 4'h6, OP_RTE = 4'h7,
        OP_SLEEP = 4'h8, OP_LDC = 4'h9, OP_STC = 4'hA, OP_FLAG_AND_IMMEDIATE = 4'hB,
        OP_ORC = 4'hC, OP_FLAG_XOR_IMMEDIATE = 4'hD, OP_MOVE = 4'hE, OP_BAD = 4'hF
    } bsmd_op_e;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_FETCH = 7'h02, S_EXT = 7'h04, S_EXEC = 7'h08,
        S_MEMOP = 7'h10, S_MOVE = 7'h20, S_SLEEP = 7'h40
    } bsmd_state_e;

    typedef struct packed {
        bsmd_op_e op;
        logic [3:0] op2;
        logic [3:0] cond;
        logic [1:0] amode;
        logic [2:0] areg;
        logic [3:0] dreg;
        logic [7:0] imm;
        logic [1:0] ext_words;
    } bsmd_fields_s;

    typedef struct packed {
        logic req;
        logic we;
        logic byte_sz;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bsmd_mreq_s;

endpackage : bsmd_pkg
